// [rtl/isp_pkg.sv]
`default_nettype none
package isp_pkg;
   // Unlock gate
   localparam logic [5:0] unlock_pattern = 6'h26;
   localparam int unlock_hold_cycles = 8;
   localparam logic [3:0] unlock_count_load = 4'h8;
   // Forced boot pin hold and debounce
   localparam int debounce_cycles = 16;
   localparam logic [4:0] debounce_count_max = 5'h10;
   // Serial commands
   localparam logic [7:0] cmd_set_timing = 8'h3b;
   localparam logic [7:0] cmd_page_erase = 8'hb3;
   localparam logic [7:0] cmd_mass_erase = 8'hbf;
   localparam logic [7:0] cmd_read_byte = 8'h1d;
   localparam logic [7:0] cmd_multi_read = 8'ha3;
   localparam logic [7:0] cmd_write_byte = 8'h71;
   localparam logic [7:0] cmd_multi_write = 8'h8f;
   localparam logic [7:0] cmd_exit = 8'hd3;
   localparam logic [7:0] blank_byte = 8'hff;
   localparam logic [15:0] option_addr = 16'hffff;
   localparam logic [14:0] option_index = 15'h7fff;
   localparam logic [15:0] max_read_count = 16'h7fff;
   localparam logic [4:0] max_write_count = 5'h10;
   // Reset values
   localparam logic [7:0] timing_reset = 8'h7b;
   localparam logic [7:0] addr_reset = 8'h00;
   localparam logic [14:0] boot_vector = 15'h0000;
   localparam logic [14:0] flash_vector = 15'h0000;
   // Option register fields
   localparam int opt_flash_boot_bit = 1;
   localparam int opt_protect_bit = 0;
   localparam logic [7:0] opt_erased = 8'hff;
   // Shifter width
   localparam logic [2:0] last_bit = 3'h7;
endpackage : isp_pkg
`default_nettype wire

// [rtl/isp_byte_if.sv]
`default_nettype none
// Bytes crossing between the link shifter and the command engine
interface isp_byte_if;
   logic rx_toggle; // Flips once per received byte
   logic [7:0] rx_byte; // Stable while toggle is settled
   logic [7:0] tx_byte; // Byte to shift out next
   logic tx_toggle; // Flips when tx_byte is loaded
   modport engine (input rx_toggle, input rx_byte, output tx_byte, output tx_toggle);
   modport shifter (output rx_toggle, output rx_byte, input tx_byte, input tx_toggle);
endinterface : isp_byte_if
`default_nettype wire

// [rtl/isp_link_shifter.sv]
`default_nettype none
// Serial slave shifter on the shift clock; msb first
module isp_link_shifter
   import isp_pkg::*;
(
   // Link clock domain
   input wire logic serial_shift_clock,
   input wire logic rst,
   input wire logic serial_in,
   output logic serial_out,
   // Byte side
   isp_byte_if.shifter bus
);
   logic [2:0] bit_cnt_ff; // Bits gathered in this byte
   logic [7:0] sh_in_ff; // Incoming shift register
   logic [7:0] sh_out_ff; // Outgoing shift register
   logic rx_tog_ff; // Byte received event
   logic [7:0] rx_byte_ff; // Held received byte
   logic [1:0] tx_sync_ff; // Load event sync, first stage unread
   logic tx_seen_ff; // Last consumed load toggle
   logic [7:0] tx_hold_ff; // Byte captured after sync
   wire byte_done = (bit_cnt_ff == last_bit); // Eighth edge of a byte
   wire tx_new = tx_sync_ff[1] ^ tx_seen_ff; // New reply pending

   // Eight edges per byte; reply shifted from byte boundary
   always_ff @(posedge serial_shift_clock or posedge rst) begin // [RL25]
      if (rst) begin
         bit_cnt_ff <= 3'h0;
         sh_in_ff <= 8'h00;
         rx_tog_ff <= 1'b0;
         rx_byte_ff <= 8'h00;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         sh_in_ff <= {sh_in_ff[6:0], serial_in};
         if (byte_done) begin
            rx_byte_ff <= {sh_in_ff[6:0], serial_in};
            rx_tog_ff <= ~rx_tog_ff;
         end
      end
   end

   // Reply path; pad byte is all ones when nothing is pending
   always_ff @(posedge serial_shift_clock or posedge rst) begin
      if (rst) begin
         tx_sync_ff <= 2'h0;
         tx_seen_ff <= 1'b0;
         sh_out_ff <= blank_byte;
         tx_hold_ff <= blank_byte;
      end else begin
         tx_sync_ff <= {tx_sync_ff[0], bus.tx_toggle};
         if (tx_new) begin
            tx_seen_ff <= tx_sync_ff[1];
            tx_hold_ff <= bus.tx_byte;
         end
         if (byte_done) begin
            sh_out_ff <= tx_hold_ff;
            tx_hold_ff <= blank_byte;
         end else begin
            sh_out_ff <= {sh_out_ff[6:0], 1'b1};
         end
      end
   end

   assign serial_out = sh_out_ff[7];
   assign bus.rx_toggle = rx_tog_ff;
   assign bus.rx_byte = rx_byte_ff;
endmodule : isp_link_shifter
`default_nettype wire

// [rtl/isp_flash_port.sv]
`default_nettype none
// Flash array with option byte; one access per cycle
module isp_flash_port
   import isp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Access
   input wire logic wr_en,
   input wire logic [14:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic page_erase,
   input wire logic mass_erase,
   input wire logic [14:0] rd_addr,
   output logic [7:0] rd_data,
   // Option byte
   input wire logic opt_wr,
   input wire logic [7:0] opt_wr_data,
   output logic [7:0] opt_ff
);
   logic [7:0] mem [0:32767]; // Program array
   logic [7:0] opt_reg_ff; // Option byte store
   wire [14:0] page_base = {wr_addr[14:6], 6'h00}; // Page start
   integer i;

   // Array updates; erased state is all ones
   always_ff @(posedge mclk) begin
      // Sweep only on an erase strobe; idle cycles stay cheap
      if (mass_erase || page_erase) begin
         for (i = 0; i < 32768; i = i + 1) begin
            if (mass_erase || (i[14:6] == page_base[14:6]))
               mem[i] <= opt_erased;
         end
      end
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end

   // Protection clears only on mass erase or user write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         opt_reg_ff <= opt_erased;
      else if (mass_erase)
         opt_reg_ff <= opt_erased & ~(8'h01 << opt_protect_bit); // [RL12]
      else if (page_erase && wr_addr == option_index)
         opt_reg_ff <= opt_reg_ff | 8'hfe;
      else if (opt_wr)
         opt_reg_ff <= opt_wr_data;
   end

   assign opt_ff = opt_reg_ff;
endmodule : isp_flash_port
`default_nettype wire

// [rtl/isp_boot_entry.sv]
`default_nettype none
// Behaviour
// [RL1] Unlock pattern in bits 7..2, low bits ignored
// [RL2] Match raises flag eight cycles; mismatch not
// [RL3] Boot jump enters ROM only when flagged
// [RL4] Return instruction goes back to flash
// [RL5] Breakpoint in emulation freezes unlock counter
// [RL6] Counter keeps running through interrupt entry
// [RL7] Software disables interrupts, jumps promptly
// [RL8] High voltage at release starts boot ROM
// [RL9] Host holds high voltage three cycles past
// [RL10] Plain reset afterwards starts flash at zero
// [RL11] Forced boot leaves option bits untouched
// [RL12] Protection clears only by mass erase
// [RL13] Load clock driven on shift pin under voltage
// [RL14] Wait pin low, debounce, then serve commands
// [RL15] Exit command resets into flash
// [RL16] Host sends timing command first
// [RL17] Page erase and mass erase, no reply
// [RL18] Read byte, protected ones, option address
// [RL19] Multi read with count, protected ones
// [RL20] Write byte programs one location
// [RL21] Multi write up to sixteen bytes
// [RL22] Unknown command ignored entirely
// [RL23] Timing register resets to ten megahertz value
// [RL24] Address registers reset to zero
// [RL25] Eight shift edges per byte, device slave
module isp_boot_entry
   import isp_pkg::*;
(
   // Core clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Core unlock register write and instructions
   input wire logic unlock_wr,
   input wire logic [7:0] unlock_wdata,
   input wire logic jump_to_boot_instr,
   input wire logic return_to_flash_instr,
   input wire logic [14:0] jump_target,
   input wire logic emu_breakpoint,
   // Fetch redirect
   output logic fetch_load,
   output logic fetch_boot_rom,
   output logic [14:0] fetch_addr,
   output logic unlock_flag,
   // Force boot pin (level detector output)
   input wire logic force_boot_pin,
   // Link pins
   input wire logic serial_shift_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic shift_clock_pin_out,
   output logic shift_clock_pin_oe,
   // Status
   output logic isp_active,
   output logic [7:0] write_pulse_timing_reg,
   output logic [7:0] prog_addr_high,
   output logic [7:0] prog_addr_low
);
   typedef enum {st_idle, st_par1, st_par2, st_par3, st_par4, st_data, st_send} cmd_state_type;

   isp_byte_if link ();

   // Unlock gate
   logic [3:0] unlock_cnt_ff; // Cycles left on the flag
   logic unlock_flag_ff;
   wire key_match = (unlock_wdata[7:2] == unlock_pattern); // [RL1]

   // Flag set for eight cycles; breakpoint freezes, interrupts do not
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         unlock_cnt_ff <= 4'h0;
      end else if (unlock_wr && key_match) begin
         unlock_cnt_ff <= unlock_count_load; // [RL2]
      end else if (unlock_cnt_ff != 4'h0 && !emu_breakpoint) begin
         unlock_cnt_ff <= unlock_cnt_ff - 4'h1; // [RL5] [RL6]
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         unlock_flag_ff <= 1'b0;
      else
         unlock_flag_ff <= (unlock_wr && key_match) || (unlock_cnt_ff > 4'h1) ||
                           (unlock_cnt_ff == 4'h1 && emu_breakpoint);
   end
   assign unlock_flag = unlock_flag_ff;

   // Force pin sync and capture at reset release
   logic [1:0] pin_sync_ff; // First stage read only by second
   logic forced_ff, first_ff; // Boot forced on this reset; cycle after release
   logic [4:0] deb_cnt_ff; // Debounce of pin low
   logic serve_ff, exit_req_ff; // Serving commands; self reset request

   // No reset: the strap must be settled two edges before the first edge after release
   always_ff @(posedge mclk) pin_sync_ff <= {pin_sync_ff[0], force_boot_pin};

   // Strap caught at release; flag bits not touched here
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         first_ff <= 1'b1;
         forced_ff <= 1'b0;
      end else begin
         first_ff <= 1'b0;
         if (first_ff)
            forced_ff <= pin_sync_ff[1]; // [RL8] [RL10] [RL11]
      end
   end

   // Debounce pin low before serving
   always_ff @(posedge mclk or posedge rst) begin // [RL14]
      if (rst) begin
         deb_cnt_ff <= 5'h00;
         serve_ff <= 1'b0;
      end else if (!forced_ff || exit_req_ff) begin
         deb_cnt_ff <= 5'h00;
         serve_ff <= 1'b0;
      end else if (pin_sync_ff[1]) begin
         deb_cnt_ff <= 5'h00;
      end else if (deb_cnt_ff != debounce_count_max) begin
         deb_cnt_ff <= deb_cnt_ff + 5'h01;
      end else begin
         serve_ff <= 1'b1;
      end
   end

   // Load clock on shift pin while voltage high
   logic sk_out_ff, sk_oe_ff; // Load clock and its enable
   always_ff @(posedge mclk or posedge rst) begin // [RL13]
      if (rst) begin
         sk_out_ff <= 1'b0;
         sk_oe_ff <= 1'b0;
      end else begin
         sk_oe_ff <= pin_sync_ff[1];
         sk_out_ff <= pin_sync_ff[1] & ~sk_out_ff;
      end
   end
   assign shift_clock_pin_out = sk_out_ff;
   assign shift_clock_pin_oe = sk_oe_ff;

   // Receive crossing
   logic [2:0] rx_sync_ff; // Stage 0 feeds stage 1 only
   wire rx_event = rx_sync_ff[2] ^ rx_sync_ff[1];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         rx_sync_ff <= 3'h0;
      else
         rx_sync_ff <= {rx_sync_ff[1:0], link.rx_toggle};
   end
   wire [7:0] rx = link.rx_byte;

   // Command engine
   cmd_state_type st_ff;
   logic [7:0] cmd_ff, timing_ff; // Command and pulse timing
   logic [7:0] ahi_ff, alo_ff; // Programming address bytes
   logic [15:0] count_ff;
   logic [7:0] tx_byte_ff, wr_data_ff; // Reply and write data
   logic tx_tog_ff, wr_en_ff;
   logic [14:0] rd_addr_ff;
   logic perase_ff, merase_ff; // One-cycle erase strobes
   logic [7:0] flash_rd, opt; // Array read and option byte
   wire [15:0] addr16 = {ahi_ff, alo_ff};
   wire protect = opt[opt_protect_bit];
   wire known = (rx == cmd_set_timing) || (rx == cmd_page_erase) || (rx == cmd_mass_erase) ||
                (rx == cmd_read_byte) || (rx == cmd_multi_read) || (rx == cmd_write_byte) ||
                (rx == cmd_multi_write) || (rx == cmd_exit);
   wire [7:0] rd_value = (cmd_ff == cmd_read_byte && addr16 == option_addr) ? opt :
                         (protect ? blank_byte : flash_rd); // [RL18] [RL19]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff <= st_idle;
         cmd_ff <= 8'h00;
         timing_ff <= timing_reset; // [RL23]
         ahi_ff <= addr_reset; // [RL24]
         alo_ff <= addr_reset; // [RL24]
         count_ff <= 16'h0000;
         tx_byte_ff <= blank_byte;
         tx_tog_ff <= 1'b0;
         wr_en_ff <= 1'b0;
         wr_data_ff <= 8'h00;
         perase_ff <= 1'b0;
         merase_ff <= 1'b0;
         exit_req_ff <= 1'b0;
      end else begin
         wr_en_ff <= 1'b0;
         perase_ff <= 1'b0;
         merase_ff <= 1'b0;
         exit_req_ff <= 1'b0;
         case (st_ff)
            st_idle: begin
               if (serve_ff && rx_event && known) begin // [RL22]
                  cmd_ff <= rx;
                  if (rx == cmd_exit && opt[opt_flash_boot_bit])
                     exit_req_ff <= 1'b1; // [RL15]
                  else if (rx != cmd_exit)
                     st_ff <= st_par1;
               end
            end
            st_par1: begin
               if (rx_event) begin
                  if (cmd_ff == cmd_set_timing) begin
                     timing_ff <= rx; // [RL16]
                     st_ff <= st_idle;
                  end else if (cmd_ff == cmd_mass_erase) begin
                     merase_ff <= 1'b1; // [RL17]
                     st_ff <= st_idle;
                  end else begin
                     ahi_ff <= rx;
                     st_ff <= st_par2;
                  end
               end
            end
            st_par2: begin
               if (rx_event) begin
                  alo_ff <= rx;
                  if (cmd_ff == cmd_page_erase) begin
                     perase_ff <= 1'b1; // [RL17]
                     st_ff <= st_idle;
                  end else if (cmd_ff == cmd_read_byte) begin
                     count_ff <= 16'h0001;
                     st_ff <= st_send;
                  end else begin
                     st_ff <= st_par3;
                  end
               end
            end
            st_par3: begin
               if (rx_event) begin
                  if (cmd_ff == cmd_multi_read) begin
                     count_ff <= {rx, 8'h00};
                     st_ff <= st_par4;
                  end else if (cmd_ff == cmd_write_byte) begin
                     wr_data_ff <= rx;
                     wr_en_ff <= 1'b1; // [RL20]
                     st_ff <= st_idle;
                  end else begin
                     count_ff <= {8'h00, rx};
                     st_ff <= (rx == 8'h00 || rx > {3'h0, max_write_count}) ? st_idle : st_data; // [RL21]
                  end
               end
            end
            st_par4: begin
               if (rx_event) begin
                  count_ff <= {count_ff[15:8], rx} & max_read_count;
                  st_ff <= ({count_ff[15:8], rx} & max_read_count) == 16'h0000 ? st_idle : st_send; // [RL19]
               end
            end
            st_data: begin
               if (rx_event) begin
                  wr_data_ff <= rx;
                  wr_en_ff <= 1'b1; // [RL21]
                  count_ff <= count_ff - 16'h0001;
                  if (count_ff == 16'h0001)
                     st_ff <= st_idle;
               end
               if (wr_en_ff)
                  alo_ff <= alo_ff + 8'h01;
            end
            st_send: begin
               // Reply loaded after array latency; one per received pad byte
               if (rx_event) begin
                  tx_byte_ff <= rd_value;
                  tx_tog_ff <= ~tx_tog_ff;
                  {ahi_ff, alo_ff} <= addr16 + 16'h0001;
                  count_ff <= count_ff - 16'h0001;
                  if (count_ff == 16'h0001)
                     st_ff <= st_idle;
               end
            end
            default: st_ff <= st_idle;
         endcase
      end
   end

   // Read address follows the programming address registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         rd_addr_ff <= 15'h0000;
      else
         rd_addr_ff <= addr16[14:0];
   end

   assign link.tx_byte = tx_byte_ff;
   assign link.tx_toggle = tx_tog_ff;

   isp_link_shifter u_shift (
      .serial_shift_clock(serial_shift_clock),
      .rst(rst),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .bus(link)
   );

   isp_flash_port u_flash (
      .mclk(mclk),
      .rst(rst),
      .wr_en(wr_en_ff),
      .wr_addr(wr_en_ff ? {ahi_ff[6:0], alo_ff} : addr16[14:0]),
      .wr_data(wr_data_ff),
      .page_erase(perase_ff),
      .mass_erase(merase_ff),
      .rd_addr(rd_addr_ff),
      .rd_data(flash_rd),
      .opt_wr(1'b0),
      .opt_wr_data(8'h00),
      .opt_ff(opt)
   );

   // Fetch redirection
   logic fl_ff, fb_ff; // Redirect strobe and target space
   logic [14:0] fa_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fl_ff <= 1'b0;
         fb_ff <= 1'b0;
         fa_ff <= 15'h0000;
      end else begin
         fl_ff <= first_ff || jump_to_boot_instr || return_to_flash_instr || exit_req_ff;
         if (first_ff) begin
            fb_ff <= pin_sync_ff[1]; // [RL8] [RL10]
            fa_ff <= pin_sync_ff[1] ? boot_vector : flash_vector;
         end else if (exit_req_ff) begin
            fb_ff <= 1'b0; // [RL15]
            fa_ff <= flash_vector;
         end else if (jump_to_boot_instr) begin
            fb_ff <= unlock_flag_ff; // [RL3]
            fa_ff <= jump_target;
         end else if (return_to_flash_instr) begin
            fb_ff <= 1'b0; // [RL4]
            fa_ff <= jump_target;
         end
      end
   end
   assign fetch_load = fl_ff;
   assign fetch_boot_rom = fb_ff;
   assign fetch_addr = fa_ff;
   assign isp_active = serve_ff;
   assign write_pulse_timing_reg = timing_ff;
   assign prog_addr_high = ahi_ff;
   assign prog_addr_low = alo_ff;

   // Flag holds exactly eight cycles with no breakpoint
   unlock_width_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
      (unlock_wr && key_match) ##1 (!emu_breakpoint && !unlock_wr)[*8] |->
      (unlock_flag_ff && $past(unlock_flag_ff, 7)) ##1 !unlock_flag_ff)
      else $error("unlock flag width wrong");
   unlock_miss_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
      (unlock_wr && !key_match && unlock_cnt_ff == 4'h0) |=> !unlock_flag_ff)
      else $error("unlock flag set by bad key");
   boot_gate_a: assert property (@(posedge mclk) disable iff (rst) // [RL3]
      (jump_to_boot_instr && !first_ff && !exit_req_ff) |=> fetch_load && fetch_boot_rom == $past(unlock_flag_ff))
      else $error("boot jump gate wrong");
   break_freeze_a: assert property (@(posedge mclk) disable iff (rst) // [RL5]
      (emu_breakpoint && !unlock_wr) |=> unlock_cnt_ff == $past(unlock_cnt_ff))
      else $error("unlock counter moved in breakpoint");
   debounce_a: assert property (@(posedge mclk) disable iff (rst) // [RL14]
      $rose(serve_ff) |-> !$past(pin_sync_ff[1]) && $past(deb_cnt_ff) == debounce_count_max)
      else $error("serving before debounce");
   timing_reset_a: assert property (@(posedge mclk) // [RL23]
      $fell(rst) |-> timing_ff == timing_reset && ahi_ff == addr_reset && alo_ff == addr_reset)
      else $error("timing or address reset wrong");
   ignore_cmd_a: assert property (@(posedge mclk) disable iff (rst) // [RL22]
      (st_ff == st_idle && rx_event && !known) |=> st_ff == st_idle && $stable(tx_tog_ff))
      else $error("unknown command not ignored");
   shift_pin_a: assert property (@(posedge mclk) disable iff (rst) // [RL13]
      pin_sync_ff[1] |=> shift_clock_pin_oe)
      else $error("load clock not driven");
endmodule : isp_boot_entry
`default_nettype wire

// [test/isp_host_model.sv]
`default_nettype none
// Host programmer: link clock runs only inside a byte frame
module isp_host_model (
   // Link pins
   output logic serial_shift_clock,
   output logic serial_in,
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last_rx; // Byte the device sent in the last frame
   // Idle: clock parked low
   initial begin
      serial_shift_clock = 1'b0;
      serial_in = 1'b1;
   end
   // One byte each way, msb first, 80 ns per bit
   task automatic xfer(input logic [7:0] tx);
      #3;
      for (int i = 7; i >= 0; i--) begin
         serial_in = tx[i];
         // Device shifts on the rising edge, so its bit is read just before it
         #40 last_rx[i] = serial_out;
         serial_shift_clock = 1'b1;
         #40 serial_shift_clock = 1'b0;
      end
      // Released line must not keep the last bit
      serial_in = ~tx[0];
      // Gap lets the engine take the byte
      #400;
   endtask
endmodule // isp_host_model
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
// Drives the boot entry block from the core and the link side
module testbench
   import isp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, unlock_wr, jump_to_boot_instr, return_to_flash_instr, emu_breakpoint, force_boot_pin;
   logic [7:0] unlock_wdata, tim, ahi, alo;
   logic [14:0] jump_target, fetch_addr, seen_addr;
   logic sck, sdi, sdo, fetch_load, fetch_boot_rom, unlock_flag, pin_out, pin_oe, isp_active;
   logic seen, seen_boot; // Last redirect, latched so a pulse is not missed
   int n_mismatch, cmp_count;
   isp_boot_entry dut_u (.mclk(mclk), .rst(rst), .unlock_wr(unlock_wr), .unlock_wdata(unlock_wdata),
      .jump_to_boot_instr(jump_to_boot_instr), .return_to_flash_instr(return_to_flash_instr),
      .jump_target(jump_target), .emu_breakpoint(emu_breakpoint), .fetch_load(fetch_load),
      .fetch_boot_rom(fetch_boot_rom), .fetch_addr(fetch_addr), .unlock_flag(unlock_flag),
      .force_boot_pin(force_boot_pin), .serial_shift_clock(sck), .serial_in(sdi), .serial_out(sdo),
      .shift_clock_pin_out(pin_out), .shift_clock_pin_oe(pin_oe), .isp_active(isp_active),
      .write_pulse_timing_reg(tim), .prog_addr_high(ahi), .prog_addr_low(alo));
   isp_host_model host_u (.serial_shift_clock(sck), .serial_in(sdi), .serial_out(sdo));
   // Core clock, 8 ns
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Catch fetch redirects
   always @(posedge mclk) begin
      if (fetch_load === 1'b1) begin
         seen <= 1'b1;
         seen_boot <= fetch_boot_rom;
         seen_addr <= fetch_addr;
      end
   end
   task automatic results();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Protected parts read back blank
   function automatic logic [7:0] shown(input logic [7:0] d);
      return opt_erased[opt_protect_bit] ? blank_byte : d;
   endfunction
   // Reset held two cycles while the strap fills its synchroniser; pin held past release
   task automatic do_reset(input logic hv);
      @(posedge mclk);
      force_boot_pin <= hv;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(3);
   endtask
   task automatic fetch_is(input logic boot, input logic [14:0] a);
      for (int k = 0; k < 200 && seen !== 1'b1; k++) @(negedge mclk);
      chk("fetch_load", 1'b1, seen);
      chk("fetch_boot_rom", boot, seen_boot);
      chk("fetch_addr", a, seen_addr);
      seen = 1'b0;
   endtask
   task automatic unlock(input logic [7:0] d);
      @(posedge mclk);
      unlock_wr <= 1'b1;
      unlock_wdata <= d;
      @(posedge mclk);
      unlock_wr <= 1'b0;
   endtask
   task automatic flag_span(output int n);
      n = 0;
      for (int k = 0; k < 60; k++) begin
         @(negedge mclk);
         if (unlock_flag === 1'b1) n++;
      end
   endtask
   task automatic instr(input logic boot);
      @(posedge mclk);
      jump_to_boot_instr <= boot;
      return_to_flash_instr <= !boot;
      @(posedge mclk);
      jump_to_boot_instr <= 1'b0;
      return_to_flash_instr <= 1'b0;
   endtask
   task automatic tx(input logic [7:0] q[$]);
      foreach (q[i]) host_u.xfer(q[i]);
   endtask
   task automatic rd(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] e);
      // First pad fetches, second carries the crossing, third brings the byte
      tx('{cmd_read_byte, ah, al, 8'h00, 8'h00, 8'h00});
      chk("read byte", e, host_u.last_rx);
   endtask
   task automatic t_unlock();
      int n;
      chk("timing", timing_reset, tim);
      chk("addr", 16'h0000, {ahi, alo});
      unlock({~unlock_pattern, 2'b00});
      flag_span(n);
      chk("flag span bad key", 0, n[15:0]);
      unlock({unlock_pattern, 2'b01});
      flag_span(n);
      chk("flag span", unlock_hold_cycles, n[15:0]);
   endtask
   task automatic t_jump();
      int n;
      jump_target <= 15'h1234;
      instr(1'b1);
      fetch_is(1'b0, 15'h1234);
      unlock({unlock_pattern, 2'b10});
      instr(1'b1);
      fetch_is(1'b1, 15'h1234);
      instr(1'b0);
      fetch_is(1'b0, 15'h1234);
      cyc(20);
      @(posedge mclk) emu_breakpoint <= 1'b1;
      unlock({unlock_pattern, 2'b11});
      cyc(20);
      chk("flag frozen", 1'b1, unlock_flag);
      @(posedge mclk) emu_breakpoint <= 1'b0;
      flag_span(n);
      chk("flag resumes", 1'b1, n > 0 && n <= unlock_hold_cycles);
   endtask
   task automatic t_force();
      do_reset(1'b1);
      fetch_is(1'b1, boot_vector);
      chk("pin_oe", 1'b1, pin_oe);
      chk("isp_active", 1'b0, isp_active);
      @(posedge mclk) force_boot_pin <= 1'b0;
      cyc(8);
      chk("debounce", 1'b0, isp_active);
      for (int k = 0; k < 60 && isp_active !== 1'b1; k++) @(negedge mclk);
      chk("isp_active", 1'b1, isp_active);
      tx('{cmd_set_timing, 8'h5a});
      chk("timing", 8'h5a, tim);
      tx('{8'h00});
      chk("timing kept", 8'h5a, tim);
      rd(8'hff, 8'hff, opt_erased);
      tx('{cmd_write_byte, 8'h00, 8'h10, 8'ha5});
      rd(8'h00, 8'h10, shown(8'ha5));
      tx('{cmd_mass_erase, 8'h55});
      rd(8'h00, 8'h10, blank_byte);
      tx('{cmd_write_byte, 8'h00, 8'h10, 8'ha5});
      rd(8'h00, 8'h10, 8'ha5);
      tx('{cmd_multi_write, 8'h00, 8'h20, 8'h02, 8'h11, 8'h22});
      tx('{cmd_multi_read, 8'h00, 8'h20, 8'h00, 8'h02, 8'h00, 8'h00});
      host_u.xfer(8'h00);
      chk("multi read 0", 8'h11, host_u.last_rx);
      host_u.xfer(8'h00);
      chk("multi read 1", 8'h22, host_u.last_rx);
      tx('{cmd_page_erase, 8'h00, 8'h20});
      rd(8'h00, 8'h20, blank_byte);
      tx('{cmd_exit});
      fetch_is(1'b0, flash_vector);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      {unlock_wr, jump_to_boot_instr, return_to_flash_instr, emu_breakpoint, force_boot_pin} = 5'h00;
      unlock_wdata = 8'h00;
      jump_target = 15'h0000;
      {seen, seen_boot, seen_addr} = 17'h00000;
      n_mismatch = 0;
      cmp_count = 0;
      do_reset(1'b0);
      fetch_is(1'b0, flash_vector);
      t_unlock();
      t_jump();
      t_force();
      do_reset(1'b0);
      fetch_is(1'b0, flash_vector);
      results();
   end
   // Watchdog against a hung handshake
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule // testbench
`default_nettype wire
